// file: nor_host_cfg.svh
`ifndef NOR_HOST_CFG_SVH
`define NOR_HOST_CFG_SVH

`define ADDR_W 23
`define DATA_W 16
`define CNT_W 16

`define UNLOCK1_ADDR 23'h000555
`define UNLOCK2_ADDR 23'h0002aa
`define UNLOCK1_DATA 16'h00aa
`define UNLOCK2_DATA 16'h0055
`define ID_ENTRY_DATA 16'h0090
`define ID_EXIT_DATA 16'h00f0
`define PROG_SETUP_DATA 16'h00a0
`define BUF_LOAD_DATA 16'h0025
`define BUF_COMMIT_DATA 16'h0029
`define ERASE_SETUP_DATA 16'h0080
`define SECT_ERASE_DATA 16'h0030
`define CHIP_ERASE_DATA 16'h0010
`define SUSPEND_DATA 16'h00b0
`define BASE_ADDR 23'h000000

`define ID_MAKER_OFS 23'h000000
`define ID_DEV1_OFS 23'h000001
`define ID_SECT_LOCK_OFS 23'h000002
`define ID_SECURE_OFS 23'h000003
`define ID_DEV2_OFS 23'h00000e
`define ID_DEV3_OFS 23'h00000f
`define ID_LOW_MASK 23'h00000f

`define BUF_MIN_WORDS 6'h01
`define BUF_MAX_WORDS 6'h20

`define CLK_NS 10
`define T_WS_NS 10
`define T_WP_NS 35
`define T_WPH_NS 20
`define T_ACC_NS 120
`define T_RP_NS 500
`define T_ADD_WINDOW_US 50
`define WS_CYC (((`T_WS_NS) + (`CLK_NS) - 1) / (`CLK_NS))
`define WP_CYC (((`T_WP_NS) + (`CLK_NS) - 1) / (`CLK_NS))
`define WPH_CYC (((`T_WPH_NS) + (`CLK_NS) - 1) / (`CLK_NS))
`define ACC_CYC (((`T_ACC_NS) + (`CLK_NS) - 1) / (`CLK_NS))
`define RP_CYC (((`T_RP_NS) + (`CLK_NS) - 1) / (`CLK_NS))
`define ADD_WINDOW_CYC (((`T_ADD_WINDOW_US) * 1000) / (`CLK_NS))

`endif

// file: nor_host_pkg.sv
package nor_host_pkg;
  typedef enum logic [3:0] {
    CMD_ID_ENTRY,
    CMD_ID_EXIT,
    CMD_ID_READ,
    CMD_HV_ID_READ,
    CMD_READ,
    CMD_PROGRAM,
    CMD_BUF_OPEN,
    CMD_BUF_WORD,
    CMD_BUF_COMMIT,
    CMD_SECT_ERASE,
    CMD_SECT_ADD,
    CMD_CHIP_ERASE,
    CMD_SUSPEND,
    CMD_RESET
  } cmd_type;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_PULSE,
    ST_HOLD,
    ST_READ,
    ST_RST
  } state_type;
endpackage : nor_host_pkg

// file: nor_flash_host.sv
// Function
// (R1) id entry: AA@555, 55@2AA, 90@555
// (R2) F0 anywhere leaves id mode
// (R3) id reads: maker 00, device 01/0E/0F
// (R4) offset 03 high-guard: 99 locked, 19 not
// (R5) offset 03 low-guard: 89 locked, 09 not
// (R6) sector offset 02: 01 locked, 00 unlocked
// (R7) probe id read via elevated address line
// (R8) program: unlock, A0@555, data@address
// (R9) buffer: unlock, 25@sector, count-1@sector
// (R10) buffer holds one to thirty-two words
// (R11) buffer words written after count write
// (R12) 29@sector commits buffer to array
// (R13) fill buffer fully for best throughput
// (R14) sector erase: six writes, 30@sector
// (R15) extra 30 writes add more sectors
// (R16) each extra sector within 50 us
// (R17) chip erase: sixth write 10@555
// (R18) B0 anywhere suspends erase
// (R19) reset pin aborts, returns array read
// (R20) secured region lock flag bit seven
// (R21) mismatched write abandons partial sequence
// (R22) busy until embedded algorithm ends; host is ready again after its last write hold
`timescale 1ns/100ps
`include "nor_host_cfg.svh"

module nor_flash_host #(
  parameter int ADD_WINDOW_CYC = `ADD_WINDOW_CYC
) (
  input wire logic clk_sys_in, // 100 MHz clock
  input wire logic nrst_in, // sync reset, active low
  input wire logic cmd_valid_in, // command request
  input wire nor_host_pkg::cmd_type cmd_in, // command code
  input wire logic [`ADDR_W-1:0] addr_in, // word address or sector address
  input wire logic [`DATA_W-1:0] data_in, // program data
  input wire logic [5:0] count_in, // buffer word count 1..32
  output logic cmd_ready_out, // idle, takes a command
  output logic done_out, // command finished pulse
  output logic err_out, // command refused pulse
  output logic [`DATA_W-1:0] rd_data_out, // read data
  output logic rd_valid_out, // read data pulse
  output logic id_mode_out, // id mode entered
  output logic flash_ce_n_out, // chip select, low active
  output logic flash_oe_n_out, // output enable, low active
  output logic flash_we_n_out, // write enable, low active
  output logic flash_rst_n_out, // reset pin, low active
  output logic elevated_probe_out, // id_probe_address_line at elevated level
  output logic [`ADDR_W-1:0] flash_addr_out, // word address
  output logic [`DATA_W-1:0] flash_dq_out, // data to flash
  output logic flash_dq_oe_out, // high while driving data
  input wire logic [`DATA_W-1:0] flash_dq_in // data from flash
);
  import nor_host_pkg::*;

  state_type state_q;
  cmd_type cmd_q;
  logic [`ADDR_W-1:0] addr_q;
  logic [`DATA_W-1:0] data_q;
  logic [2:0] step_q;
  logic [`CNT_W-1:0] tmr_q;
  logic [`CNT_W-1:0] win_q;
  logic id_mode_q;
  logic buf_open_q;
  logic [5:0] buf_cnt_q;
  logic [5:0] buf_load_q;

  // step table
  logic [`ADDR_W-1:0] tab_addr;
  logic [`DATA_W-1:0] tab_data;
  logic [2:0] seq_last;
  always_comb
  begin
    tab_addr = `UNLOCK1_ADDR;
    tab_data = `UNLOCK1_DATA;
    seq_last = 3'h0;
    case (cmd_q)
      CMD_ID_ENTRY:
      begin
        seq_last = 3'h2;
        if (step_q == 3'h1)
        begin
          tab_addr = `UNLOCK2_ADDR; // [R1]
          tab_data = `UNLOCK2_DATA;
        end
        else if (step_q == 3'h2)
          tab_data = `ID_ENTRY_DATA; // [R1]
      end
      CMD_ID_EXIT:
      begin
        tab_addr = `BASE_ADDR;
        tab_data = `ID_EXIT_DATA; // [R2]
      end
      CMD_PROGRAM:
      begin
        seq_last = 3'h3;
        if (step_q == 3'h1)
        begin
          tab_addr = `UNLOCK2_ADDR;
          tab_data = `UNLOCK2_DATA;
        end
        else if (step_q == 3'h2)
          tab_data = `PROG_SETUP_DATA; // [R8]
        else if (step_q == 3'h3)
        begin
          tab_addr = addr_q; // [R8]
          tab_data = data_q;
        end
      end
      CMD_BUF_OPEN:
      begin
        seq_last = 3'h3;
        if (step_q == 3'h1)
        begin
          tab_addr = `UNLOCK2_ADDR;
          tab_data = `UNLOCK2_DATA;
        end
        else if (step_q == 3'h2)
        begin
          tab_addr = addr_q; // [R9]
          tab_data = `BUF_LOAD_DATA;
        end
        else if (step_q == 3'h3)
        begin
          tab_addr = addr_q; // [R9]
          tab_data = {10'h000, buf_cnt_q - 6'h01};
        end
      end
      CMD_BUF_WORD:
      begin
        tab_addr = addr_q; // [R11]
        tab_data = data_q;
      end
      CMD_BUF_COMMIT:
      begin
        tab_addr = addr_q; // [R12]
        tab_data = `BUF_COMMIT_DATA;
      end
      CMD_SECT_ERASE, CMD_CHIP_ERASE:
      begin
        seq_last = 3'h5;
        if (step_q == 3'h1 || step_q == 3'h4)
        begin
          tab_addr = `UNLOCK2_ADDR; // [R14]
          tab_data = `UNLOCK2_DATA;
        end
        else if (step_q == 3'h2)
          tab_data = `ERASE_SETUP_DATA; // [R14]
        else if (step_q == 3'h5 && cmd_q == CMD_SECT_ERASE)
        begin
          tab_addr = addr_q; // [R14]
          tab_data = `SECT_ERASE_DATA;
        end
        else if (step_q == 3'h5)
          tab_data = `CHIP_ERASE_DATA; // [R17]
      end
      CMD_SECT_ADD:
      begin
        tab_addr = addr_q; // [R15]
        tab_data = `SECT_ERASE_DATA;
      end
      CMD_SUSPEND:
      begin
        tab_addr = `BASE_ADDR;
        tab_data = `SUSPEND_DATA; // [R18]
      end
      default:
      begin
        tab_addr = `UNLOCK1_ADDR;
        tab_data = `UNLOCK1_DATA;
      end
    endcase
  end

  // acceptance checks
  wire take = (state_q == ST_IDLE) && cmd_ready_out && cmd_valid_in;
  wire cnt_ok = (count_in >= `BUF_MIN_WORDS) && (count_in <= `BUF_MAX_WORDS); // [R10]
  wire buf_room = buf_open_q && (buf_load_q < buf_cnt_q); // [R10]
  wire buf_full = buf_open_q && (buf_load_q == buf_cnt_q); // [R11]
  wire win_open = (win_q != '0); // [R16]
  wire is_read = (cmd_in == CMD_READ) || (cmd_in == CMD_ID_READ) || (cmd_in == CMD_HV_ID_READ);
  wire refuse = ((cmd_in == CMD_ID_READ) && !id_mode_q)
    || ((cmd_in == CMD_BUF_OPEN) && (!cnt_ok || buf_open_q))
    || ((cmd_in == CMD_BUF_WORD) && !buf_room)
    || ((cmd_in == CMD_BUF_COMMIT) && !buf_full)
    || ((cmd_in == CMD_SECT_ADD) && !win_open)
    || (buf_open_q && (cmd_in != CMD_BUF_WORD) && (cmd_in != CMD_BUF_COMMIT)
        && (cmd_in != CMD_RESET)); // [R21]
  wire [`ADDR_W-1:0] rd_addr = (cmd_in == CMD_HV_ID_READ) ? (addr_in & `ID_LOW_MASK) : addr_in; // [R7]
  wire tmr_done = (tmr_q == '0);
  wire last_step = (step_q == seq_last);
  wire seq_end = (state_q == ST_HOLD) && tmr_done && last_step;

  always_ff @(posedge clk_sys_in)
  begin
    if (!nrst_in)
    begin
      state_q <= ST_IDLE;
      cmd_q <= CMD_READ;
      addr_q <= '0;
      data_q <= '0;
      step_q <= 3'h0;
      tmr_q <= '0;
      cmd_ready_out <= 1'b0;
      done_out <= 1'b0;
      err_out <= 1'b0;
      rd_data_out <= '0;
      rd_valid_out <= 1'b0;
      flash_ce_n_out <= 1'b1;
      flash_oe_n_out <= 1'b1;
      flash_we_n_out <= 1'b1;
      flash_rst_n_out <= 1'b0; // [R19]
      elevated_probe_out <= 1'b0;
      flash_addr_out <= '0;
      flash_dq_out <= '0;
      flash_dq_oe_out <= 1'b0;
    end
    else
    begin
      done_out <= 1'b0;
      err_out <= 1'b0;
      rd_valid_out <= 1'b0;
      flash_rst_n_out <= 1'b1;
      case (state_q)
        ST_IDLE:
        begin
          cmd_ready_out <= 1'b1;
          if (take && refuse)
            err_out <= 1'b1; // [R21]
          else if (take)
          begin
            cmd_ready_out <= 1'b0; // [R22]
            cmd_q <= cmd_in;
            addr_q <= addr_in;
            data_q <= data_in;
            step_q <= 3'h0;
            if (cmd_in == CMD_RESET)
            begin
              state_q <= ST_RST;
              flash_rst_n_out <= 1'b0; // [R19]
              tmr_q <= `CNT_W'(`RP_CYC - 1);
            end
            else if (is_read)
            begin
              state_q <= ST_READ;
              flash_ce_n_out <= 1'b0; // [R7]
              flash_oe_n_out <= 1'b0;
              elevated_probe_out <= (cmd_in == CMD_HV_ID_READ); // [R7]
              flash_addr_out <= rd_addr; // [R3]
              tmr_q <= `CNT_W'(`ACC_CYC - 1);
            end
            else
            begin
              state_q <= ST_SETUP;
              // address and data stand a full cycle before we falls
              tmr_q <= `CNT_W'(`WS_CYC);
            end
          end
        end
        ST_SETUP:
        begin
          flash_ce_n_out <= 1'b0;
          flash_addr_out <= tab_addr;
          flash_dq_out <= tab_data;
          flash_dq_oe_out <= 1'b1;
          tmr_q <= tmr_q - `CNT_W'(1);
          if (tmr_done)
          begin
            state_q <= ST_PULSE;
            flash_we_n_out <= 1'b0;
            tmr_q <= `CNT_W'(`WP_CYC - 1);
          end
        end
        ST_PULSE:
        begin
          tmr_q <= tmr_q - `CNT_W'(1);
          if (tmr_done)
          begin
            state_q <= ST_HOLD;
            flash_we_n_out <= 1'b1;
            tmr_q <= `CNT_W'(`WPH_CYC - 1);
          end
        end
        ST_HOLD:
        begin
          tmr_q <= tmr_q - `CNT_W'(1);
          if (tmr_done && !last_step)
          begin
            state_q <= ST_SETUP;
            step_q <= step_q + 3'h1;
            tmr_q <= `CNT_W'(`WS_CYC);
          end
          else if (tmr_done)
          begin
            state_q <= ST_IDLE;
            flash_ce_n_out <= 1'b1;
            flash_dq_oe_out <= 1'b0;
            done_out <= 1'b1;
            cmd_ready_out <= 1'b1;
          end
        end
        ST_READ:
        begin
          tmr_q <= tmr_q - `CNT_W'(1);
          if (tmr_done)
          begin
            state_q <= ST_IDLE;
            rd_data_out <= flash_dq_in; // [R4] [R5] [R6] [R20]
            rd_valid_out <= 1'b1;
            done_out <= 1'b1;
            cmd_ready_out <= 1'b1;
            flash_ce_n_out <= 1'b1;
            flash_oe_n_out <= 1'b1;
            elevated_probe_out <= 1'b0;
          end
        end
        ST_RST:
        begin
          flash_rst_n_out <= 1'b0;
          tmr_q <= tmr_q - `CNT_W'(1);
          if (tmr_done)
          begin
            state_q <= ST_IDLE;
            flash_rst_n_out <= 1'b1;
            done_out <= 1'b1;
            cmd_ready_out <= 1'b1;
          end
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // host view of device mode
  wire reset_ev = (state_q == ST_RST);
  always_ff @(posedge clk_sys_in)
  begin
    if (!nrst_in || reset_ev)
    begin
      id_mode_q <= 1'b0; // [R19]
      buf_open_q <= 1'b0;
      buf_cnt_q <= 6'h00;
      buf_load_q <= 6'h00;
      win_q <= '0;
    end
    else
    begin
      if (take && !refuse && cmd_in == CMD_BUF_OPEN)
        buf_cnt_q <= count_in; // [R9]
      if (seq_end && cmd_q == CMD_ID_ENTRY)
        id_mode_q <= 1'b1; // [R1]
      else if (seq_end && cmd_q == CMD_ID_EXIT)
        id_mode_q <= 1'b0; // [R2]
      if (seq_end && cmd_q == CMD_BUF_OPEN)
      begin
        buf_open_q <= 1'b1;
        buf_load_q <= 6'h00;
      end
      else if (seq_end && cmd_q == CMD_BUF_WORD)
        buf_load_q <= buf_load_q + 6'h01; // [R11]
      else if (seq_end && cmd_q == CMD_BUF_COMMIT)
        buf_open_q <= 1'b0; // [R12]
      if (seq_end && (cmd_q == CMD_SECT_ERASE || cmd_q == CMD_SECT_ADD))
        win_q <= `CNT_W'(ADD_WINDOW_CYC); // [R16]
      else if (win_open)
        win_q <= win_q - `CNT_W'(1);
    end
  end

  assign id_mode_out = id_mode_q;
endmodule : nor_flash_host

// file: nor_host_monitor.sv
`timescale 1ns/100ps
`include "nor_host_cfg.svh"
module nor_host_monitor #(
  parameter int ADD_WINDOW_CYC = 20
) (
  input wire logic clk_sys_in, // clock
  input wire logic nrst_in, // reset
  input wire logic cmd_valid_in, // request
  input wire nor_host_pkg::cmd_type cmd_in, // code
  input wire logic cmd_ready_out, // idle
  input wire logic done_out, // finished
  input wire logic err_out, // refused
  input wire logic rd_valid_out, // read data
  input wire logic flash_ce_n_out, // select
  input wire logic flash_oe_n_out, // output enable
  input wire logic flash_we_n_out, // write enable
  input wire logic flash_rst_n_out, // reset pin
  input wire logic elevated_probe_out, // probe
  input wire logic [`ADDR_W-1:0] flash_addr_out, // address
  input wire logic flash_dq_oe_out // data enable
);
  import nor_host_pkg::*;
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!nrst_in);
  wire take = cmd_valid_in && cmd_ready_out;
  sequence we_low_s;
    !flash_we_n_out[*4];
  endsequence
  sequence we_high_s;
    flash_we_n_out[*2];
  endsequence
  write_strobe_a: assert property ($fell(flash_we_n_out) |-> we_low_s ##1 we_high_s)
    else $error("write strobe width wrong");
  write_setup_a: assert property ($fell(flash_we_n_out) |->
    $past(!flash_ce_n_out) && flash_dq_oe_out && flash_oe_n_out)
    else $error("write without setup");
  write_addr_a: assert property (!flash_we_n_out && $past(!flash_we_n_out) |->
    $stable(flash_addr_out))
    else $error("address moved in write");
  read_strobe_a: assert property (!flash_oe_n_out |->
    flash_we_n_out && !flash_ce_n_out && !flash_dq_oe_out)
    else $error("read strobe clash");
  probe_read_a: assert property (elevated_probe_out |-> !flash_oe_n_out && flash_we_n_out)
    else $error("probe outside read");
  refuse_idle_a: assert property (err_out |-> cmd_ready_out && !done_out && !rd_valid_out)
    else $error("refusal not idle");
  suspend_time_a: assert property (take && cmd_in == CMD_SUSPEND |-> ##[7:9] done_out)
    else $error("suspend late");
  read_time_a: assert property (take && (cmd_in == CMD_READ || cmd_in == CMD_HV_ID_READ) |->
    ##[12:14] (rd_valid_out && done_out))
    else $error("read late");
  reset_pulse_a: assert property ($fell(flash_rst_n_out) |->
    !flash_rst_n_out[*8] ##[42:44] flash_rst_n_out)
    else $error("reset pulse width wrong");
  reset_exit_a: assert property ($rose(nrst_in) |-> ##1 cmd_ready_out && flash_rst_n_out)
    else $error("not ready after reset");
endmodule : nor_host_monitor
bind nor_flash_host nor_host_monitor #(.ADD_WINDOW_CYC(ADD_WINDOW_CYC)) mon_u (
  .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in),
  .cmd_ready_out(cmd_ready_out), .done_out(done_out), .err_out(err_out),
  .rd_valid_out(rd_valid_out), .flash_ce_n_out(flash_ce_n_out), .flash_oe_n_out(flash_oe_n_out),
  .flash_we_n_out(flash_we_n_out), .flash_rst_n_out(flash_rst_n_out),
  .elevated_probe_out(elevated_probe_out), .flash_addr_out(flash_addr_out),
  .flash_dq_oe_out(flash_dq_oe_out));

// file: flash_model.sv
`timescale 1ns/100ps
module flash_model (
  input wire logic ce_n_in, // select
  input wire logic oe_n_in, // output enable
  input wire logic we_n_in, // write enable
  input wire logic rst_n_in, // reset pin
  input wire logic probe_in, // elevated probe
  input wire logic [22:0] addr_in, // address
  input wire logic [15:0] dq_in, // bus level
  output logic [15:0] dq_out // data to host
);
  logic [38:0] wlog[$];
  logic [1:0] seq_q;
  logic id_q;
  logic [15:0] rd_d;
  always @(posedge we_n_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      seq_q <= 2'h0;
      id_q <= 1'h0;
    end
    else if (!ce_n_in)
    begin
      wlog.push_back({addr_in, dq_in});
      seq_q <= 2'h0;
      if (dq_in == 16'hf0)
        id_q <= 1'h0;
      else if (seq_q == 2'h0 && addr_in == 23'h555 && dq_in == 16'haa)
        seq_q <= 2'h1;
      else if (seq_q == 2'h1 && addr_in == 23'h2aa && dq_in == 16'h55)
        seq_q <= 2'h2;
      else if (seq_q == 2'h2 && addr_in == 23'h555 && dq_in == 16'h90)
        id_q <= 1'h1;
    end
  always_comb
    if (probe_in || id_q)
      case (addr_in[3:0])
        4'h0: rd_d = 16'h00c3; // arbitrary maker code
        4'h1, 4'he, 4'hf: rd_d = {12'h3c0, addr_in[3:0]}; // arbitrary device words
        4'h2: rd_d = {15'h0, addr_in[16]}; // odd sectors locked
        4'h3: rd_d = 16'h0099; // high guard, factory locked
        default: rd_d = 16'h0;
      endcase
    else
      rd_d = addr_in[15:0] ^ 16'h5a5a;
  // released bus shows the inverse so a late sample is caught
  assign dq_out = (!ce_n_in && !oe_n_in && rst_n_in) ? rd_d : ~rd_d;
endmodule : flash_model

// file: testbench.sv
`timescale 1ns/100ps
module testbench;
  import nor_host_pkg::*;
  logic clk_sys_in = 1'h0, nrst_in = 1'h0, cmd_valid_in = 1'h0;
  cmd_type cmd_in = CMD_READ;
  logic [22:0] addr_in = 23'h0, fa;
  logic [15:0] data_in = 16'h0, fdq, mdq, rdo, rdv;
  logic [5:0] count_in = 6'h0;
  logic rdy, done, err, rv, idm, ce, oe, we, rn, pr, dqoe, errf;
  int fail_count = 0, checks_done = 0;
  wire [15:0] bus = dqoe ? fdq : mdq;
  always #5 clk_sys_in = ~clk_sys_in;
  nor_flash_host #(.ADD_WINDOW_CYC(20)) dut_u (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
    .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in), .addr_in(addr_in), .data_in(data_in),
    .count_in(count_in), .cmd_ready_out(rdy), .done_out(done), .err_out(err),
    .rd_data_out(rdo), .rd_valid_out(rv), .id_mode_out(idm), .flash_ce_n_out(ce),
    .flash_oe_n_out(oe), .flash_we_n_out(we), .flash_rst_n_out(rn), .elevated_probe_out(pr),
    .flash_addr_out(fa), .flash_dq_out(fdq), .flash_dq_oe_out(dqoe), .flash_dq_in(bus));
  flash_model m_u (.ce_n_in(ce), .oe_n_in(oe), .we_n_in(we), .rst_n_in(rn), .probe_in(pr),
    .addr_in(fa), .dq_in(bus), .dq_out(mdq));
  task automatic chk(input logic [38:0] g, input logic [38:0] e);
    checks_done++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic w(input logic [22:0] a, input logic [15:0] d);
    chk(m_u.wlog.pop_front(), {a, d});
  endtask : w
  task automatic e6(input logic [22:0] a, input logic [15:0] d);
    w(23'h555, 16'haa);
    w(23'h2aa, 16'h55);
    w(23'h555, 16'h80);
    w(23'h555, 16'haa);
    w(23'h2aa, 16'h55);
    w(a, d);
  endtask : e6
  task automatic cmd(input cmd_type c, input logic [22:0] a, input logic [15:0] d,
    input logic [5:0] n);
    int k;
    cmd_in = c;
    addr_in = a;
    data_in = d;
    count_in = n;
    cmd_valid_in = 1'h1;
    @(posedge clk_sys_in);
    #1 cmd_valid_in = 1'h0;
    errf = err;
    for (k = 0; k < 300 && errf !== 1'h1; k++)
    begin
      @(posedge clk_sys_in);
      #1;
      if (rv === 1'h1)
        rdv = rdo;
      if (done === 1'h1)
        break;
    end
    if (errf === 1'h1)
    begin
      @(posedge clk_sys_in);
      #1;
    end
    chk(k < 300, 1'h1);
  endtask : cmd
  task automatic t_id();
    logic [22:0] ad[7] = '{23'h0, 23'h1, 23'he, 23'hf, 23'h3, 23'h10002, 23'h2};
    logic [15:0] ev[7] = '{16'h00c3, 16'h3c01, 16'h3c0e, 16'h3c0f, 16'h0099, 16'h1, 16'h0};
    cmd(CMD_ID_ENTRY, 23'h0, 16'h0, 6'h0);
    w(23'h555, 16'haa);
    w(23'h2aa, 16'h55);
    w(23'h555, 16'h90);
    chk(idm, 1'h1);
    for (int i = 0; i < 7; i++)
    begin
      cmd(CMD_ID_READ, ad[i], 16'h0, 6'h0);
      chk(rdv, ev[i]);
    end
    cmd(CMD_ID_EXIT, 23'h0, 16'h0, 6'h0);
    w(23'h0, 16'hf0);
    chk(idm, 1'h0);
    cmd(CMD_ID_READ, 23'h0, 16'h0, 6'h0);
    chk(errf, 1'h1);
    cmd(CMD_HV_ID_READ, 23'h7ffff1, 16'h0, 6'h0);
    chk(rdv, 16'h3c01);
  endtask : t_id
  task automatic t_prog();
    cmd(CMD_PROGRAM, 23'h123456, 16'hbeef, 6'h0);
    w(23'h555, 16'haa);
    w(23'h2aa, 16'h55);
    w(23'h555, 16'ha0);
    w(23'h123456, 16'hbeef);
    cmd(CMD_BUF_OPEN, 23'h50000, 16'h0, 6'h0);
    chk(errf, 1'h1);
    cmd(CMD_BUF_OPEN, 23'h50000, 16'h0, 6'h21);
    chk(errf, 1'h1);
    cmd(CMD_BUF_OPEN, 23'h50000, 16'h0, 6'h20);
    w(23'h555, 16'haa);
    w(23'h2aa, 16'h55);
    w(23'h50000, 16'h25);
    w(23'h50000, 16'h1f);
    for (int i = 0; i < 32; i++)
    begin
      cmd(CMD_BUF_WORD, 23'h50000 + 23'(i), 16'h1000 + 16'(i), 6'h0);
      w(23'h50000 + 23'(i), 16'h1000 + 16'(i));
    end
    cmd(CMD_BUF_WORD, 23'h50020, 16'h0, 6'h0);
    chk(errf, 1'h1);
    cmd(CMD_BUF_COMMIT, 23'h50000, 16'h0, 6'h0);
    w(23'h50000, 16'h29);
  endtask : t_prog
  task automatic t_era();
    cmd(CMD_SECT_ERASE, 23'h20000, 16'h0, 6'h0);
    e6(23'h20000, 16'h30);
    cmd(CMD_SECT_ADD, 23'h30000, 16'h0, 6'h0);
    w(23'h30000, 16'h30);
    repeat (30) @(posedge clk_sys_in);
    #1 cmd(CMD_SECT_ADD, 23'h40000, 16'h0, 6'h0);
    chk(errf, 1'h1);
    chk(m_u.wlog.size(), 0);
    cmd(CMD_CHIP_ERASE, 23'h0, 16'h0, 6'h0);
    e6(23'h555, 16'h10);
    cmd(CMD_SUSPEND, 23'h0, 16'h0, 6'h0);
    w(23'h0, 16'hb0);
    cmd(CMD_ID_ENTRY, 23'h0, 16'h0, 6'h0);
    m_u.wlog.delete();
    cmd(CMD_RESET, 23'h0, 16'h0, 6'h0);
    chk(idm, 1'h0);
    cmd(CMD_READ, 23'h1, 16'h0, 6'h0);
    chk(rdv, 16'h5a5b);
  endtask : t_era
  task end_sim();
    $display("checks %0d, errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  initial
  begin
    repeat (20) @(posedge clk_sys_in);
    #1 chk(rn, 1'h0);
    nrst_in = 1'h1;
    @(posedge clk_sys_in);
    #1 chk(rn, 1'h1);
    t_id();
    t_prog();
    t_era();
    end_sim();
  end
  initial
  begin
    #100000;
    fail_count++;
    end_sim();
  end
endmodule : testbench
